// File: fogl_regs.vh
`ifndef FOGL_REGS_VH
`define FOGL_REGS_VH

// Register offsets (byte addresses, one 32-bit word each)
`define FOGL_ADDR_CTRL      8'h00
`define FOGL_ADDR_ALTCFG    8'h04
`define FOGL_ADDR_DEVSTAT   8'h08
`define FOGL_ADDR_WAKESTAT2 8'h0C
`define FOGL_ADDR_LEVEL     8'h10
`define FOGL_ADDR_COUNTS    8'h14

// Control register fields
`define FOGL_CTRL_TEST_FORCE 0
`define FOGL_CTRL_OV_EN      1
`define FOGL_CTRL_DUTY_LSB   2
`define FOGL_CTRL_CFG_LSB    4
`define FOGL_CTRL_RESET      6'h00

// Alternate-function register fields
`define FOGL_ALT_P2_LSB    0
`define FOGL_ALT_P3_LSB    3
`define FOGL_ALT_P2_SW     6
`define FOGL_ALT_P3_SW     7
`define FOGL_ALT_RESET     8'h00

// Alternate-function codes per pin
`define FOGL_FN_FAIL  3'h0
`define FOGL_FN_OFF   3'h1
`define FOGL_FN_WAKE  3'h2
`define FOGL_FN_LS    3'h3
`define FOGL_FN_HS    3'h4

// Device modes as delivered by the mode state machine
`define FOGL_MODE_INIT     3'h0
`define FOGL_MODE_NORMAL   3'h1
`define FOGL_MODE_STOP     3'h2
`define FOGL_MODE_SLEEP    3'h3
`define FOGL_MODE_RESTART  3'h4
`define FOGL_MODE_FAILSAFE 3'h5

// Failure counts
`define FOGL_UV_LIMIT   3'h4
`define FOGL_WD_LIMIT   2'h2

// Timing
`define FOGL_CLK_NS       10
`define FOGL_IND_HALF_MS  400
`define FOGL_PUL_PER_MS   10
`define FOGL_IND_HALF_CYC (`FOGL_IND_HALF_MS * 1000000 / `FOGL_CLK_NS)
`define FOGL_PUL_PER_CYC  (`FOGL_PUL_PER_MS * 1000000 / `FOGL_CLK_NS)

`endif

// File: fogl_sync.v
`timescale 1ns/10ps
`default_nettype none

module fogl_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         nrst,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);

   ////////////////////////////////////////////////////////////////////////////
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_bit
         reg meta_q;
         reg sync_q;
         // Two flops per bit; only the second is ever read
         always @(posedge clk or negedge nrst)
         begin
            if (!nrst)
            begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end
            else
            begin
               meta_q <= d[i];
               sync_q <= meta_q;
            end
         end
         assign q[i] = sync_q;
      end
   endgenerate

endmodule // fogl_sync

`default_nettype wire

// File: fogl_wave.v
`timescale 1ns/10ps
`default_nettype none

module fogl_wave #(
   parameter [25:0] IND_HALF = 26'h2625A00,
   parameter [19:0] PUL_PER  = 20'hF4240
) (
   input  wire       clk,
   input  wire       nrst,
   input  wire       run,
   input  wire [1:0] duty,
   output reg        ind_low_q,
   output reg        pul_low_q
);

   reg  [25:0] ind_cnt_q;
   reg  [19:0] pul_cnt_q;
   reg         ind_ph_q;
   reg  [19:0] low_len;

   // Low time: 20, 10, 5 or 2.5 percent of the period
   always @*
   begin
      case (duty)
         2'h0:    low_len = PUL_PER / 20'h5;
         2'h1:    low_len = PUL_PER / 20'hA;
         2'h2:    low_len = PUL_PER / 20'h14;
         default: low_len = PUL_PER / 20'h28;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counters sit at zero while idle so each activation starts a fresh phase
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ind_cnt_q <= 26'h0;
         pul_cnt_q <= 20'h0;
         ind_ph_q  <= 1'b0;
         ind_low_q <= 1'b0;
         pul_low_q <= 1'b0;
      end
      else if (!run)
      begin
         ind_cnt_q <= 26'h0;
         pul_cnt_q <= 20'h0;
         ind_ph_q  <= 1'b0;
         ind_low_q <= 1'b0;
         pul_low_q <= 1'b0;
      end
      else
      begin
         // Half period count, phase flips: 50 percent duty
         if (ind_cnt_q == IND_HALF - 26'h1)
         begin
            ind_cnt_q <= 26'h0;
            ind_ph_q  <= ~ind_ph_q;
         end
         else
            ind_cnt_q <= ind_cnt_q + 26'h1;
         if (pul_cnt_q == PUL_PER - 20'h1)
            pul_cnt_q <= 20'h0;
         else
            pul_cnt_q <= pul_cnt_q + 20'h1;
         ind_low_q <= ~ind_ph_q;
         pul_low_q <= (pul_cnt_q < low_len);
      end
   end

endmodule // fogl_wave

`default_nettype wire

// File: fogl_top.v
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "fogl_regs.vh"

// How it works
// - Three open-drain fail pins pull low to signal failure.
// - Severe thermal shutdown, rail short and other faults activate the fail pins.
// - Watchdog failures activate after second failure (config 3/4), first (config 1/2).
// - Rail overvoltage activates only while overvoltage enable bit is one.
// - Four consecutive rail undervoltage events activate the fail pins.
// - Activation also requests fail-safe; watchdog cases follow hardware configuration.
// - Every activation sets the fail-active flag.
// - Test-force bit drives fail pins independently of failure bits.
// - Clearing test-force turns pins off when no failure exists.
// - In normal mode, clear needs faults gone and flag cleared by software.
// - Watchdog flag also clears on non-watchdog failure or watchdog off in stop.
// - In config 2 the first watchdog failure leaves fail flag unset.
// - All three activate together; first pin held statically low.
// - Indicator pin blinks 1.25 Hz at 50 percent while active.
// - Pulsed pin runs 100 Hz with 20 percent low time.
// - Pulsed duty selectable 20, 10, 5, 2.5 percent; 20 after reset.
// - Pins two and three default to fail function; alternates selectable.
// - Wake-configured pin detects wake-ups and records them in wake status two.
// - Switch-configured pin just turns on or off under register control.
// - Pin levels reported in normal and stop modes, switches included.
// - Mode table: configure in normal, freeze in stop/sleep, restart/fail-safe limits.
// - Pin configured off stays off in every mode.
// - Leaving restart resumes switch function, configuration untouched; wake function keeps running through restart.
// - Activated fail outputs persist through restart and into normal mode.
module fogl_top #(
   parameter [25:0] IND_HALF_CYC = `FOGL_IND_HALF_CYC,
   parameter [19:0] PUL_PER_CYC  = `FOGL_PUL_PER_CYC
) (
   input  wire        clk,
   input  wire        nrst,
   input  wire [7:0]  addr,
   input  wire [31:0] wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [31:0] rdata,
   input  wire [2:0]  mode,
   input  wire        severe_thermal_shutdown,
   input  wire        rail_short,
   input  wire        rail_overvoltage,
   input  wire        rail_undervoltage,
   input  wire        watchdog_fail_flag_event,
   input  wire        wd_trigger_ok,
   input  wire        wd_disabled_stop,
   input  wire        indicator_fail_pin_in,
   input  wire        pulsed_fail_pin_in,
   output reg         static_fail_pin_oe,
   output reg         indicator_fail_pin_out,
   output reg         indicator_fail_pin_oe,
   output reg         pulsed_fail_pin_out,
   output reg         pulsed_fail_pin_oe,
   output reg         failsafe_req,
   output reg         wake_req
);

   reg  [5:0]  ctrl_q;
   reg  [7:0]  alt_q;
   reg         fail_flag_q;
   reg         fail_latch_q;
   reg         wd_flag_q;
   reg  [1:0]  wd_cnt_q;
   reg  [2:0]  uv_cnt_q;
   reg         uv_prev_q;
   reg         nonwd_prev_q;
   reg  [1:0]  pin_prev_q;
   reg  [1:0]  wake_stat_q;
   reg  [1:0]  level_q;
   wire [3:0]  flt_s;
   wire [1:0]  pin_s;
   wire        ind_low;
   wire        pul_low;

   ////////////////////////////////////////////////////////////////////////////
   // Analog fault comparators and pin receivers come from outside the clock
   fogl_sync #(
      .W (4)
   ) u_sync_flt (
      .clk  (clk),
      .nrst (nrst),
      .d    ({rail_undervoltage, rail_overvoltage, rail_short, severe_thermal_shutdown}),
      .q    (flt_s)
   );

   fogl_sync #(
      .W (2)
   ) u_sync_pin (
      .clk  (clk),
      .nrst (nrst),
      .d    ({pulsed_fail_pin_in, indicator_fail_pin_in}),
      .q    (pin_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Decoded control fields
   wire       test_force_bit          = ctrl_q[`FOGL_CTRL_TEST_FORCE];
   wire       overvoltage_fail_enable = ctrl_q[`FOGL_CTRL_OV_EN];
   wire [1:0] pulsed_duty_select      = ctrl_q[`FOGL_CTRL_DUTY_LSB +: 2];
   wire [1:0] hw_cfg                  = ctrl_q[`FOGL_CTRL_CFG_LSB +: 2];
   wire [2:0] fn2                     = alt_q[`FOGL_ALT_P2_LSB +: 3];
   wire [2:0] fn3                     = alt_q[`FOGL_ALT_P3_LSB +: 3];
   wire       sw2                     = alt_q[`FOGL_ALT_P2_SW];
   wire       sw3                     = alt_q[`FOGL_ALT_P3_SW];

   wire m_normal   = (mode == `FOGL_MODE_NORMAL);
   wire m_stop     = (mode == `FOGL_MODE_STOP);
   wire m_restart  = (mode == `FOGL_MODE_RESTART);
   wire m_failsafe = (mode == `FOGL_MODE_FAILSAFE);

   // Bus decode; settings are only writable in normal mode, frozen elsewhere
   wire wr_ctrl  = wr && (addr == `FOGL_ADDR_CTRL) && m_normal;
   wire wr_alt   = wr && (addr == `FOGL_ADDR_ALTCFG) && m_normal;
   wire wr_dev   = wr && (addr == `FOGL_ADDR_DEVSTAT);
   wire wr_wake  = wr && (addr == `FOGL_ADDR_WAKESTAT2);

   ////////////////////////////////////////////////////////////////////////////
   // Failure causes
   wire uv_evt      = flt_s[3] & ~uv_prev_q;
   wire uv_hit      = uv_evt && (uv_cnt_q == `FOGL_UV_LIMIT - 3'h1);
   wire nonwd_lvl   = flt_s[0] | flt_s[1] | (flt_s[2] & overvoltage_fail_enable);
   wire nonwd_rise  = (nonwd_lvl & ~nonwd_prev_q) | uv_hit;
   // Config 3/4 need a failure already counted, config 1/2 fire at once
   wire cfg_late    = hw_cfg[1];
   wire wd_hit      = watchdog_fail_flag_event && (!cfg_late || (wd_cnt_q != 2'h0));
   // Config 2 first failure drives the pins without raising the flag
   wire wd_noflag   = (hw_cfg == 2'h1) && (wd_cnt_q == 2'h0);
   wire fail_evt    = nonwd_rise | wd_hit;
   wire flag_evt    = nonwd_rise | (wd_hit & ~wd_noflag);
   // Causes still standing block any clear
   wire cause_now   = nonwd_lvl | wd_flag_q | flt_s[3];
   wire clr_req     = wr_dev && wdata[0] && m_normal && !cause_now;
   wire fail_active = fail_latch_q | test_force_bit;

   ////////////////////////////////////////////////////////////////////////////
   // Failure latch, flag and counters
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         fail_latch_q <= 1'b0;
         fail_flag_q  <= 1'b0;
         wd_flag_q    <= 1'b0;
         wd_cnt_q     <= 2'h0;
         uv_cnt_q     <= 3'h0;
         uv_prev_q    <= 1'b0;
         nonwd_prev_q <= 1'b0;
         failsafe_req <= 1'b0;
      end
      else
      begin
         uv_prev_q    <= flt_s[3];
         nonwd_prev_q <= nonwd_lvl;
         // Latch holds through restart and normal entry until cleared
         if (fail_evt)
            fail_latch_q <= 1'b1;
         else if (clr_req)
            fail_latch_q <= 1'b0;
         // A new failure in the clearing cycle wins
         if (flag_evt)
            fail_flag_q <= 1'b1;
         else if (clr_req)
            fail_flag_q <= 1'b0;
         if (watchdog_fail_flag_event)
            wd_flag_q <= 1'b1;
         else if (wd_trigger_ok || nonwd_rise || (m_stop && wd_disabled_stop))
            wd_flag_q <= 1'b0;
         if (watchdog_fail_flag_event && (wd_cnt_q != `FOGL_WD_LIMIT))
            wd_cnt_q <= wd_cnt_q + 2'h1;
         else if (clr_req)
            wd_cnt_q <= 2'h0;
         // Undervoltage events count up to the limit, reset on a clean clear
         if (uv_evt && (uv_cnt_q != `FOGL_UV_LIMIT))
            uv_cnt_q <= uv_cnt_q + 3'h1;
         else if (clr_req)
            uv_cnt_q <= 3'h0;
         // Config 1 and 3 send watchdog failures to fail-safe, 2 and 4 restart
         failsafe_req <= nonwd_rise | (wd_hit & ~hw_cfg[0]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers; only reset or a normal-mode write change them,
   // so restart never disturbs the stored alternate function
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_q <= `FOGL_CTRL_RESET;
         alt_q  <= `FOGL_ALT_RESET;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_q <= wdata[5:0];
         if (wr_alt)
            alt_q <= wdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   fogl_wave #(
      .IND_HALF (IND_HALF_CYC),
      .PUL_PER  (PUL_PER_CYC)
   ) u_wave (
      .clk       (clk),
      .nrst      (nrst),
      .run       (fail_active),
      .duty      (pulsed_duty_select),
      .ind_low_q (ind_low),
      .pul_low_q (pul_low)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Per-pin function under the current mode
   reg  ind_oe_d;
   reg  ind_out_d;
   reg  pul_oe_d;
   reg  pul_out_d;
   reg  act_q;
   reg  [1:0] wake_cap;

   always @*
   begin
      ind_oe_d  = 1'b0;
      ind_out_d = 1'b0;
      pul_oe_d  = 1'b0;
      pul_out_d = 1'b0;
      wake_cap  = 2'h0;
      // Indicator pin
      case (fn2)
         `FOGL_FN_FAIL:
            ind_oe_d = fail_active & ind_low;
         `FOGL_FN_WAKE:
            wake_cap[0] = ~m_failsafe;
         `FOGL_FN_LS:
            ind_oe_d = sw2 & ~m_restart & ~m_failsafe;
         `FOGL_FN_HS:
         begin
            ind_oe_d  = sw2 & ~m_restart & ~m_failsafe;
            ind_out_d = 1'b1;
         end
         default:
            ind_oe_d = 1'b0;
      endcase
      // Pulsed pin
      case (fn3)
         `FOGL_FN_FAIL:
            pul_oe_d = fail_active & pul_low;
         `FOGL_FN_WAKE:
            wake_cap[1] = ~m_failsafe;
         `FOGL_FN_LS:
            pul_oe_d = sw3 & ~m_restart & ~m_failsafe;
         `FOGL_FN_HS:
         begin
            pul_oe_d  = sw3 & ~m_restart & ~m_failsafe;
            pul_out_d = 1'b1;
         end
         default:
            pul_oe_d = 1'b0;
      endcase
   end

   // Static pin waits one cycle so all three pins start together
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         act_q <= 1'b0;
         static_fail_pin_oe     <= 1'b0;
         indicator_fail_pin_oe  <= 1'b0;
         indicator_fail_pin_out <= 1'b0;
         pulsed_fail_pin_oe     <= 1'b0;
         pulsed_fail_pin_out    <= 1'b0;
      end
      else
      begin
         act_q <= fail_active;
         static_fail_pin_oe     <= fail_active & act_q;
         indicator_fail_pin_oe  <= ind_oe_d;
         indicator_fail_pin_out <= ind_out_d;
         pulsed_fail_pin_oe     <= pul_oe_d;
         pulsed_fail_pin_out    <= pul_out_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wake detection on either edge, same as the dedicated wake pins
   wire [1:0] pin_edge = (pin_s ^ pin_prev_q) & wake_cap;
   wire       lvl_upd  = m_normal | m_stop;

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_prev_q  <= 2'h0;
         wake_stat_q <= 2'h0;
         level_q     <= 2'h0;
         wake_req    <= 1'b0;
      end
      else
      begin
         pin_prev_q <= pin_s;
         // Set wins over a same-cycle write-one clear
         wake_stat_q <= pin_edge | (wake_stat_q & ~({2{wr_wake}} & wdata[1:0]));
         if (lvl_upd)
            level_q <= pin_s;
         wake_req <= |pin_edge;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port; data stand in the cycle after the strobe only
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rdata <= 32'h00000000;
      else if (!rd)
         rdata <= 32'h00000000;
      else
      begin
         case (addr)
            `FOGL_ADDR_CTRL:      rdata <= {26'h0, ctrl_q};
            `FOGL_ADDR_ALTCFG:    rdata <= {24'h0, alt_q};
            `FOGL_ADDR_DEVSTAT:   rdata <= {29'h0, fail_active, wd_flag_q, fail_flag_q};
            `FOGL_ADDR_WAKESTAT2: rdata <= {30'h0, wake_stat_q};
            `FOGL_ADDR_LEVEL:     rdata <= {30'h0, level_q};
            `FOGL_ADDR_COUNTS:    rdata <= {27'h0, wd_cnt_q, uv_cnt_q};
            default:              rdata <= 32'h00000000;
         endcase
      end
   end

endmodule // fogl_top

`default_nettype wire

// File: fogl_properties.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////
module fogl_properties #(
   parameter [25:0] IND_HALF_CYC = 26'h0000008,
   parameter [19:0] PUL_PER_CYC  = 20'h00050
) (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic [7:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        wr,
   input wire logic [2:0]  mode,
   input wire logic        severe_thermal_shutdown,
   input wire logic        static_fail_pin_oe,
   input wire logic        indicator_fail_pin_oe,
   input wire logic        pulsed_fail_pin_oe,
   input wire logic        failsafe_req,
   input wire logic        wake_req
);
   logic [7:0]  alt_q;
   logic [1:0]  duty_q;
   logic [25:0] ind_q;
   logic [19:0] pul_q;
   wire         on_w = static_fail_pin_oe && mode == 3'h1;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // Settings mirrored from accepted writes; only normal mode may change them
   // Run lengths count only while failure shows in normal mode
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         alt_q  <= 8'h00;
         duty_q <= 2'h0;
         ind_q  <= 26'h0000000;
         pul_q  <= 20'h00000;
      end
      else
      begin
         if (wr && mode == 3'h1 && addr == 8'h04)
            alt_q <= wdata[7:0];
         if (wr && mode == 3'h1 && addr == 8'h00)
            duty_q <= wdata[3:2];
         ind_q <= (on_w && indicator_fail_pin_oe) ? ind_q + 26'h0000001 : 26'h0000000;
         pul_q <= (on_w && pulsed_fail_pin_oe) ? pul_q + 20'h00001 : 20'h00000;
      end
   end

   ////////////////////////////////////////
   chk_force_on: assert property (wr && mode == 3'h1 && addr == 8'h00 && wdata[0] |-> ##[2:3] static_fail_pin_oe)
      else $error("test force did not drive the static pin");
   chk_fault_on: assert property (severe_thermal_shutdown [*6] |-> static_fail_pin_oe)
      else $error("thermal fault did not activate the static pin");
   chk_clear_held: assert property (wr && addr == 8'h08 && wdata[0] && static_fail_pin_oe && (mode != 3'h1 || severe_thermal_shutdown && $past(severe_thermal_shutdown, 3)) |=> static_fail_pin_oe [*3])
      else $error("fail pins cleared while a clear condition was missing");
   chk_fs_pulse: assert property (failsafe_req |=> !failsafe_req)
      else $error("fail-safe request longer than one cycle");
   chk_fs_pins: assert property (failsafe_req |-> ##[1:2] static_fail_pin_oe)
      else $error("fail-safe request without static pin");
   chk_all_together: assert property ($rose(static_fail_pin_oe) && alt_q[5:0] == 6'h00 |-> indicator_fail_pin_oe && pulsed_fail_pin_oe)
      else $error("fail pins did not start together");
   chk_ind_half: assert property (on_w && $past(on_w) && $fell(indicator_fail_pin_oe) && alt_q[2:0] == 3'h0 |-> ind_q == IND_HALF_CYC)
      else $error("indicator low phase has wrong length");
   chk_pulse_low: assert property (on_w && $past(on_w) && $fell(pulsed_fail_pin_oe) && alt_q[5:3] == 3'h0 |-> pul_q == (PUL_PER_CYC / 20'h00005) >> duty_q)
      else $error("pulsed low time does not match duty");
   chk_sw_restart: assert property (mode == 3'h4 && $past(mode) == 3'h4 && (alt_q[2:0] == 3'h3 || alt_q[2:0] == 3'h4) |-> !indicator_fail_pin_oe)
      else $error("switch left on in restart mode");
   chk_off_pin: assert property (alt_q[5:3] == 3'h1 && $past(alt_q[5:3], 2) == 3'h1 |-> !pulsed_fail_pin_oe)
      else $error("pin configured off is driven");
   chk_wake_pulse: assert property (wake_req |=> !wake_req)
      else $error("wake request longer than one cycle");
endmodule // fogl_properties

bind fogl_top fogl_properties #(
   .IND_HALF_CYC(IND_HALF_CYC),
   .PUL_PER_CYC (PUL_PER_CYC)
) u_fogl_properties (
   .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .mode(mode),
   .severe_thermal_shutdown(severe_thermal_shutdown), .static_fail_pin_oe(static_fail_pin_oe),
   .indicator_fail_pin_oe(indicator_fail_pin_oe), .pulsed_fail_pin_oe(pulsed_fail_pin_oe),
   .failsafe_req(failsafe_req), .wake_req(wake_req)
);
`default_nettype wire

// File: fogl_lamp.sv
`timescale 1ns/10ps
`default_nettype none
module fogl_lamp (
   input  wire logic oe,
   input  wire logic out,
   input  wire logic ext_low,
   output logic      level
);
   // Pull-up holds the line high unless the pin or an outside contact sinks it
   assign level = ext_low ? 1'b0 : (oe ? out : 1'b1);
endmodule // fogl_lamp
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        clk;
   logic        nrst;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [2:0]  mode;
   logic        tsd;
   logic        rshort;
   logic        rov;
   logic        ruv;
   logic        wdf;
   logic        wdok;
   logic        wdis;
   logic        ext2;
   logic        fs_seen;
   logic        wk_seen;
   logic [31:0] v;
   wire  [31:0] rdata;
   wire         st_oe;
   wire         ind_oe;
   wire         ind_out;
   wire         pul_oe;
   wire         pul_out;
   wire         fs_req;
   wire         wk_req;
   wire         lv1;
   wire         lv2;
   wire         lv3;
   int          failures;
   int          compares;

   // Short counts keep the blink and pulse periods within a brief run
   fogl_top #(.IND_HALF_CYC(26'h0000008), .PUL_PER_CYC(20'h00050)) u_fogl_top (
      .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .mode(mode), .severe_thermal_shutdown(tsd), .rail_short(rshort), .rail_overvoltage(rov),
      .rail_undervoltage(ruv), .watchdog_fail_flag_event(wdf), .wd_trigger_ok(wdok),
      .wd_disabled_stop(wdis), .indicator_fail_pin_in(lv2), .pulsed_fail_pin_in(lv3),
      .static_fail_pin_oe(st_oe), .indicator_fail_pin_out(ind_out),
      .indicator_fail_pin_oe(ind_oe), .pulsed_fail_pin_out(pul_out),
      .pulsed_fail_pin_oe(pul_oe), .failsafe_req(fs_req), .wake_req(wk_req));
   fogl_lamp u_fogl_lamp_s (.oe(st_oe), .out(1'b0), .ext_low(1'b0), .level(lv1));
   fogl_lamp u_fogl_lamp_i (.oe(ind_oe), .out(ind_out), .ext_low(ext2), .level(lv2));
   fogl_lamp u_fogl_lamp_p (.oe(pul_oe), .out(pul_out), .ext_low(1'b0), .level(lv3));

   ////////////////////////////////////////
   // Clock and sticky capture of the one-cycle request pulses
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (fs_req === 1'b1)
         fs_seen <= 1'b1;
      if (wk_req === 1'b1)
         wk_seen <= 1'b1;
   end

   // Helpers; waits end 1 ns past the edge so the design's updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
      check(n, v & m, e);
   endtask
   task automatic pulse_wd(input logic ok);
      @(posedge clk);
      wdok <= ok;
      wdf <= !ok;
      @(posedge clk);
      wdok <= 1'b0;
      wdf <= 1'b0;
   endtask
   task automatic do_reset();
      nrst <= 1'b0;
      tick(12);
      nrst <= 1'b1;
      tick(1);
   endtask
   task automatic clear_fail(input string n, input logic e);
      wr_reg(8'h08, 32'h00000001);
      tick(3);
      check(n, st_oe, e);
   endtask
   task wrap_up;
      if (failures == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Hang guard, well past the length of the whole sequence
   initial
   begin
      #200000;
      failures++;
      wrap_up;
   end

   ////////////////////////////////////////
   initial
   begin
      {addr, wdata, wr, rd, tsd, rshort, rov, ruv, wdf, wdok, wdis, ext2} <= '0;
      {fs_seen, wk_seen} <= 2'b00;
      mode <= 3'h1;
      failures = 0;
      compares = 0;
      do_reset();
      rd_chk("ctrl", 8'h00, 32'hFFFFFFFF, 32'h00000000);
      rd_chk("alt", 8'h04, 32'hFFFFFFFF, 32'h00000000);
      wr_reg(8'h20, 32'hFFFFFFFF);
      rd_chk("unmapped", 8'h20, 32'hFFFFFFFF, 32'h00000000);
      // Forced pins at every duty; the checker measures each waveform
      for (int d = 0; d < 4; d++)
      begin
         wr_reg(8'h00, (d << 2) | 1);
         tick(200);
         check("static_lvl", lv1, 1'b0);
         rd_chk("force_stat", 8'h08, 32'h00000005, 32'h00000004);
         wr_reg(8'h00, 32'h00000000);
         clear_fail("force_off", 1'b0);
      end
      // Level faults: clear refused while present and outside normal mode
      for (int i = 0; i < 2; i++)
      begin
         fs_seen <= 1'b0;
         {rshort, tsd} <= 2'b01 << i;
         tick(8);
         check("fault_pin", st_oe, 1'b1);
         check("fault_fs", fs_seen, 1'b1);
         rd_chk("fault_flag", 8'h08, 32'h00000001, 32'h00000001);
         clear_fail("clr_early", 1'b1);
         {rshort, tsd} <= 2'b00;
         mode <= 3'h2;
         tick(6);
         clear_fail("clr_stop", 1'b1);
         mode <= 3'h1;
         clear_fail("clr_ok", 1'b0);
      end
      // Overvoltage counts only with its enable set
      rov <= 1'b1;
      tick(8);
      check("ov_masked", st_oe, 1'b0);
      rov <= 1'b0;
      wr_reg(8'h00, 32'h00000002);
      tick(4);
      rov <= 1'b1;
      tick(8);
      check("ov_enabled", st_oe, 1'b1);
      rov <= 1'b0;
      tick(6);
      clear_fail("ov_clr", 1'b0);
      // Watchdog failures in each hardware configuration
      for (int c = 0; c < 4; c++)
      begin
         do_reset();
         wr_reg(8'h00, c << 4);
         fs_seen <= 1'b0;
         pulse_wd(1'b0);
         tick(3);
         check("wd1_pin", st_oe, c < 2);
         rd_chk("wd1_flag", 8'h08, 32'h00000001, c == 0);
         check("wd1_fs", fs_seen, c == 0);
         pulse_wd(1'b0);
         tick(3);
         check("wd2_pin", st_oe, 1'b1);
         check("wd2_fs", fs_seen, c % 2 == 0);
         rd_chk("wd2_flag", 8'h08, 32'h00000003, 32'h00000003);
         clear_fail("wd_held", 1'b1);
         if (c < 2)
            pulse_wd(1'b1);
         else
         begin
            mode <= 3'h2;
            wdis <= 1'b1;
            tick(3);
            {mode, wdis} <= 4'h2;
         end
         rd_chk("wd_gone", 8'h08, 32'h00000002, 32'h00000000);
         clear_fail("wd_clr", 1'b0);
      end
      // Four undervoltage events, then a fresh reset
      for (int n = 1; n <= 4; n++)
      begin
         ruv <= 1'b1;
         tick(4);
         ruv <= 1'b0;
         tick(4);
         check("uv_pin", st_oe, n == 4);
      end
      rd_chk("uv_count", 8'h14, 32'h00000007, 32'h00000004);
      do_reset();
      // Switches, restart freeze, off and wake functions
      wr_reg(8'h04, 32'h000000E3);
      tick(5);
      check("ls_hs", {ind_oe, ind_out, pul_oe, pul_out}, 4'hB);
      rd_chk("levels", 8'h10, 32'h00000003, 32'h00000002);
      mode <= 3'h4;
      wr_reg(8'h04, 32'h00000000);
      tick(2);
      check("rst_off", {ind_oe, pul_oe}, 2'b00);
      mode <= 3'h5;
      tick(2);
      check("fs_off", {ind_oe, pul_oe}, 2'b00);
      mode <= 3'h1;
      tick(3);
      check("resume", {ind_oe, pul_oe}, 2'b11);
      rd_chk("cfg_kept", 8'h04, 32'h000000FF, 32'h000000E3);
      wr_reg(8'h04, 32'h0000000A);
      wr_reg(8'h00, 32'h00000001);
      tick(6);
      check("off_wake", {st_oe, ind_oe, pul_oe}, 3'b100);
      wr_reg(8'h00, 32'h00000000);
      wr_reg(8'h0C, 32'h00000003);
      wk_seen <= 1'b0;
      ext2 <= 1'b1;
      tick(6);
      check("wake_req", wk_seen, 1'b1);
      rd_chk("wake_stat", 8'h0C, 32'h00000003, 32'h00000001);
      wr_reg(8'h0C, 32'h00000001);
      rd_chk("wake_clr", 8'h0C, 32'h00000003, 32'h00000000);
      wrap_up;
   end
endmodule // tb_top
`default_nettype wire
